// ===== sfpe_flash_cmd.sv
// Serial flash command handling: DTR quad read, page program and sector erase
// Functional notes
// - Mode byte of the DTR quad read counts as the first dummy clock.
// - Read data starts right after the dummy clocks, no extra wait.
// - Continuous read mode of the DTR quad read works in four-lane mode too.
// - The 4-byte-address opcodes always take a 32-bit address.
// - The 4-byte-address DTR quad read is refused in four-lane mode.
// - Page program is refused unless the write-enable latch is set.
// - Data past the page end wraps to the page start and overwrites.
// - A partial page program leaves the other bytes of the page alone.
// - Chip select must rise on a byte boundary or the frame is dropped.
// - Chip select rise starts a timed program cycle with busy held high.
// - Write-enable latch clears when a program cycle completes.
// - Program into a protected page is skipped.
// - Quad input program needs quad enable, latch, data on four lanes.
// - Quad page program moves address and data on four lanes.
// - Both quad programs are refused in four-lane command mode.
// - Sector erase takes a 24-bit address and sets 4 KB to ones.
// - Sector erase is timed, busy held high, latch cleared at the end.
// - Erase into a protected region is skipped.
// - Mode bits 5,4 let the next read frame skip the opcode.
`timescale 1ns/1ns

module sfpe_flash_cmd #(
   parameter int AW = sfpe_pkg::MEM_AW,
   parameter int PP_CYCLES = sfpe_pkg::PP_CYC,
   parameter int SE_CYCLES = sfpe_pkg::SE_CYC
) (
   input wire logic ref_clk, // Core clock
   input wire logic rst_n, // Synchronous reset
   input wire logic ce, // Core clock enable
   input wire logic sclk, // Serial clock from host
   input wire logic cs_n, // Chip select from host
   input wire logic [3:0] io_in, // Data lanes in, lane 0 is serial_data_in
   output logic [3:0] io_out, // Data lanes out
   output logic [3:0] io_oe, // Lane drive enables
   input wire logic quad_enable, // Status quad enable bit
   input wire logic four_lane_command_mode, // Four-lane command mode active
   input wire logic [1:0] latency_code, // Read latency code
   input wire logic protect_complement, // Protection complement
   input wire logic top_bottom_select, // Protect from bottom when set
   input wire logic small_region_protect, // Protect in 4 KB units for erase only; program keeps 64 KB units
   input wire logic block_protect_bit3, // Block protect bit 3
   input wire logic block_protect_bit2, // Block protect bit 2
   input wire logic block_protect_bit1, // Block protect bit 1
   input wire logic block_protect_bit0, // Block protect bit 0
   input wire logic wel_set, // Write enable pulse
   output logic write_enable_latch, // Latch state
   output logic busy // Program or erase in progress
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [7:0] mem [0:(2**AW)-1];
   logic [7:0] pbuf [0:sfpe_pkg::PAGE_BYTES-1];
   logic [sfpe_pkg::PAGE_BYTES-1:0] mask;

   // ------------------------------------------------------------
   // Crossings
   // ------------------------------------------------------------
   logic [sfpe_pkg::LINK_SYNC_W-1:0] lsync;
   logic [1:0] csync;
   logic frame_tog;
   wire busy_l = lsync[0];
   wire wel_l = lsync[1];
   wire qe_l = lsync[2];
   wire qpi_l = lsync[3];
   wire [1:0] lc_l = lsync[5:4];
   wire link_rst_n = lsync[6];

   sfpe_sync #(.W(sfpe_pkg::LINK_SYNC_W)) u_link_sync (
      .clk(sclk),
      .en(1'b1),
      .d({rst_n, latency_code, four_lane_command_mode, quad_enable, write_enable_latch, busy}),
      .q(lsync)
   );

   sfpe_sync #(.W(2)) u_core_sync (
      .clk(ref_clk),
      .en(ce),
      .d({frame_tog, cs_n}),
      .q(csync)
   );

   // ------------------------------------------------------------
   // Link side
   // ------------------------------------------------------------
   sfpe_pkg::sfpe_lstate_t lst, next_lst;
   logic [5:0] cnt, next_cnt;
   logic [4:0] idx, next_idx;
   logic started, drive;
   logic [31:0] sh, hdr_addr, res_addr;
   logic [3:0] rise_nib, fall_nib;
   logic addr4, aquad, dquad, hdr_wide, cont, cont_wide, frame_ok;
   sfpe_pkg::sfpe_kind_t res_kind;
   logic [7:0] pidx, out_byte;
   logic [AW-1:0] rd_ptr;

   wire step_quad = (lst == sfpe_pkg::L_CMD) ? qpi_l : (lst == sfpe_pkg::L_ADDR) ? aquad : dquad;
   wire [31:0] sh_next = step_quad ? {sh[27:0], io_in} : {sh[30:0], io_in[0]};
   wire [5:0] cnt_step = cnt + (step_quad ? 6'h04 : 6'h01);
   wire [7:0] op = sh_next[7:0];
   wire [7:0] dtr_byte = {rise_nib, fall_nib};

   // Opcode decoding, only ever looked at for the first byte of a frame
   wire cont_entry = (lst == sfpe_pkg::L_CMD) && !started && cont;
   wire cmd_done = (lst == sfpe_pkg::L_CMD) && !cont_entry && (cnt_step == sfpe_pkg::CMD_BITS);
   wire op_read = (op == sfpe_pkg::OP_DTR_READ) || (op == sfpe_pkg::OP_DTR_READ4);
   wire op_quad_in = (op == sfpe_pkg::OP_QIN_PROG) || (op == sfpe_pkg::OP_QIN_PROG4);
   wire op_quad_pp = (op == sfpe_pkg::OP_QUAD_PROG);
   wire op_prog = (op == sfpe_pkg::OP_PROG) || (op == sfpe_pkg::OP_PROG4) || op_quad_in || op_quad_pp;
   wire op_erase = (op == sfpe_pkg::OP_SECT_ERASE);
   wire op_a4 = (op == sfpe_pkg::OP_PROG4) || (op == sfpe_pkg::OP_QIN_PROG4);
   wire read_ok = op_read && qe_l && !busy_l
      && !((op == sfpe_pkg::OP_DTR_READ4) && qpi_l);
   wire prog_ok = op_prog && wel_l && !busy_l
      && !((op_quad_in || op_quad_pp) && (qpi_l || !qe_l));
   wire erase_ok = op_erase && wel_l && !busy_l;
   wire cont_ok = !busy_l && qe_l && !(cont_wide && qpi_l);

   // Read header: address bytes, then dummy clocks that include the mode byte
   wire [4:0] hdr_bytes = hdr_wide ? sfpe_pkg::ADDR4_BYTES : sfpe_pkg::ADDR3_BYTES;
   wire [4:0] dummy = (lc_l == 2'h0) ? sfpe_pkg::DUMMY_LC0 : (lc_l == 2'h1) ? sfpe_pkg::DUMMY_LC1
      : (lc_l == 2'h2) ? sfpe_pkg::DUMMY_LC2 : sfpe_pkg::DUMMY_LC3;
   wire hdr_addr_step = (lst == sfpe_pkg::L_RDHDR) && (idx != 5'h00) && (idx <= hdr_bytes);
   wire hdr_mode_step = (lst == sfpe_pkg::L_RDHDR) && (idx == hdr_bytes + 5'h01);
   wire hdr_last = (lst == sfpe_pkg::L_RDHDR) && (idx == hdr_bytes + dummy - 5'h01);
   wire [5:0] abits = addr4 ? sfpe_pkg::ADDR4_BITS : sfpe_pkg::ADDR3_BITS;
   wire addr_done = (lst == sfpe_pkg::L_ADDR) && (cnt_step == abits);
   wire byte_done = (lst == sfpe_pkg::L_PROG) && (cnt_step[2:0] == 3'h0);
   wire [31:0] addr_full = addr4 ? sh_next : {8'h00, sh_next[23:0]};

   always_comb begin
      next_lst = lst;
      next_cnt = cnt_step;
      next_idx = idx;
      case (lst)
         sfpe_pkg::L_CMD: begin
            if (cont_entry) begin
               next_idx = 5'h01;
               next_lst = cont_ok ? sfpe_pkg::L_RDHDR : sfpe_pkg::L_IGNORE;
            end else if (cmd_done) begin
               next_cnt = 6'h00;
               next_idx = 5'h00;
               next_lst = read_ok ? sfpe_pkg::L_RDHDR
                  : (prog_ok || erase_ok) ? sfpe_pkg::L_ADDR : sfpe_pkg::L_IGNORE;
            end
         end
         sfpe_pkg::L_ADDR: begin
            if (addr_done) begin
               next_cnt = 6'h00;
               next_lst = (res_kind == sfpe_pkg::K_ERASE) ? sfpe_pkg::L_TAIL : sfpe_pkg::L_PROG;
            end
         end
         sfpe_pkg::L_RDHDR: begin
            next_idx = idx + 5'h01;
            if (hdr_last) begin
               next_lst = sfpe_pkg::L_RDATA;
            end
         end
         sfpe_pkg::L_TAIL: next_lst = sfpe_pkg::L_IGNORE;
         default: next_lst = lst;
      endcase
   end

   // Frame sequencing ends with the frame itself, the serial clock may stop
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         lst <= sfpe_pkg::L_CMD;
         cnt <= 6'h00;
         idx <= 5'h00;
         started <= 1'b0;
         drive <= 1'b0;
      end else begin
         lst <= next_lst;
         cnt <= next_cnt;
         idx <= next_idx;
         started <= 1'b1;
         drive <= (lst == sfpe_pkg::L_RDATA);
      end
   end

   always_ff @(negedge sclk) begin
      fall_nib <= io_in;
   end

   always_ff @(posedge sclk) begin
      sh <= sh_next;
      rise_nib <= io_in;
      if (hdr_addr_step) begin
         hdr_addr <= {hdr_addr[23:0], dtr_byte};
      end
   end

   always_ff @(posedge sclk) begin
      if (cmd_done) begin
         addr4 <= op_a4;
         aquad <= qpi_l || op_quad_pp;
         dquad <= qpi_l || op_quad_in || op_quad_pp;
         hdr_wide <= (op == sfpe_pkg::OP_DTR_READ4);
         res_kind <= op_erase ? sfpe_pkg::K_ERASE : sfpe_pkg::K_PROG;
      end else if (cont_entry) begin
         hdr_wide <= cont_wide;
      end
      if (addr_done) begin
         res_addr <= addr_full;
      end
   end

   // Continuous read state and the frame tag survive chip select
   always_ff @(posedge sclk) begin
      if (!link_rst_n) begin
         cont <= 1'b0;
         cont_wide <= 1'b0;
         frame_tog <= 1'b0;
      end else begin
         // Idle clocks with chip select high must not move the tag
         if (!started && !cs_n) begin
            frame_tog <= ~frame_tog;
         end
         if (hdr_mode_step) begin
            cont <= (dtr_byte[sfpe_pkg::MODE_HI:sfpe_pkg::MODE_LO] == sfpe_pkg::MODE_CONT);
            cont_wide <= hdr_wide;
         end
      end
   end

   // Valid only while the frame stands on a byte boundary after a whole address
   always_ff @(posedge sclk) begin
      if (!started || lst == sfpe_pkg::L_TAIL || lst == sfpe_pkg::L_IGNORE) begin
         frame_ok <= 1'b0;
      end else if (addr_done) begin
         frame_ok <= (res_kind == sfpe_pkg::K_ERASE);
      end else if (lst == sfpe_pkg::L_PROG) begin
         frame_ok <= byte_done;
      end
   end

   always_ff @(posedge sclk) begin
      if (addr_done) begin
         pidx <= sh_next[7:0];
         mask <= '0;
      end else if (byte_done) begin
         pbuf[pidx] <= sh_next[7:0];
         mask[pidx] <= 1'b1;
         pidx <= pidx + 8'h01;
      end
   end

   // Array is static while reads are let through, busy gates every read frame
   always_ff @(posedge sclk) begin
      if (hdr_last) begin
         rd_ptr <= hdr_wide ? hdr_addr[AW-1:0] : AW'({8'h00, hdr_addr[23:0]});
      end else if (lst == sfpe_pkg::L_RDATA) begin
         out_byte <= mem[rd_ptr];
         rd_ptr <= rd_ptr + AW'(1);
      end
   end

   // Upper nibble in the high half of the clock, lower nibble in the low half
   assign io_out = drive ? (sclk ? out_byte[7:4] : out_byte[3:0]) : 4'h0;
   assign io_oe = {4{drive}};

   // ------------------------------------------------------------
   // Core side
   // ------------------------------------------------------------
   sfpe_pkg::sfpe_cstate_t cst;
   sfpe_pkg::sfpe_kind_t kind_q;
   logic cs_d, tog_seen;
   logic [AW-1:0] base_q;
   logic [11:0] widx;
   logic [31:0] tmr;

   function automatic logic prot_fn(input logic [AW-1:0] a, input logic cmp, input logic tb,
                                    input logic sec, input logic [3:0] bp);
      longint size;
      longint total;
      logic hit;
      total = longint'(2) ** AW;
      size = 0;
      hit = 1'b0;
      if (bp != 4'h0) begin
         size = (sec ? sfpe_pkg::PROT_SMALL_UNIT : sfpe_pkg::PROT_BLOCK_UNIT) << (bp - 4'h1);
         if (sec && size > sfpe_pkg::PROT_SMALL_MAX) begin
            size = sfpe_pkg::PROT_SMALL_MAX;
         end
         if (size > total) begin
            size = total;
         end
         hit = tb ? (longint'(a) < size) : (longint'(a) >= total - size);
      end
      return hit ^ cmp;
   endfunction

   wire [3:0] bp = {block_protect_bit3, block_protect_bit2, block_protect_bit1, block_protect_bit0};
   wire is_prog = (res_kind == sfpe_pkg::K_PROG);
   wire prot = prot_fn(res_addr[AW-1:0], protect_complement, top_bottom_select,
                       small_region_protect && !is_prog, bp);
   wire frame_end = csync[0] && !cs_d && (csync[1] != tog_seen);
   // Link words are quiet once chip select is high and the tag has crossed
   wire trigger = frame_end && frame_ok && write_enable_latch && (cst == sfpe_pkg::C_IDLE)
      && !prot;
   wire [AW-1:0] wr_addr = base_q + AW'(widx);
   wire [11:0] wlast = (kind_q == sfpe_pkg::K_PROG) ? sfpe_pkg::PAGE_LAST : sfpe_pkg::SECTOR_LAST;
   wire [31:0] lim = (kind_q == sfpe_pkg::K_PROG) ? 32'(PP_CYCLES) : 32'(SE_CYCLES);
   wire op_end = (cst == sfpe_pkg::C_WAIT) && (tmr >= lim - 32'h1);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cs_d <= 1'b1;
         tog_seen <= 1'b0;
      end else if (ce) begin
         cs_d <= csync[0];
         if (frame_end) begin
            tog_seen <= csync[1];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cst <= sfpe_pkg::C_IDLE;
         busy <= 1'b0;
         widx <= 12'h000;
         tmr <= 32'h0;
      end else if (ce) begin
         tmr <= tmr + 32'h1;
         case (cst)
            sfpe_pkg::C_IDLE: begin
               if (trigger) begin
                  cst <= sfpe_pkg::C_WORK;
                  busy <= 1'b1;
                  widx <= 12'h000;
                  tmr <= 32'h0;
               end
            end
            sfpe_pkg::C_WORK: begin
               widx <= widx + 12'h001;
               if (widx == wlast) begin
                  cst <= sfpe_pkg::C_WAIT;
               end
            end
            sfpe_pkg::C_WAIT: begin
               if (op_end) begin
                  cst <= sfpe_pkg::C_IDLE;
                  busy <= 1'b0;
               end
            end
            default: cst <= sfpe_pkg::C_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         kind_q <= sfpe_pkg::K_NONE;
         base_q <= '0;
      end else if (ce && trigger) begin
         kind_q <= res_kind;
         base_q <= is_prog ? {res_addr[AW-1:sfpe_pkg::PAGE_AW], sfpe_pkg::PAGE_AW'(0)}
            : {res_addr[AW-1:sfpe_pkg::SECTOR_AW], sfpe_pkg::SECTOR_AW'(0)};
      end
   end

   // Programming only clears bits, so an unerased target ends up as the AND
   always_ff @(posedge ref_clk) begin
      if (ce && cst == sfpe_pkg::C_WORK) begin
         if (kind_q == sfpe_pkg::K_ERASE) begin
            mem[wr_addr] <= sfpe_pkg::ERASED_BYTE;
         end else if (mask[widx[7:0]]) begin
            mem[wr_addr] <= mem[wr_addr] & pbuf[widx[7:0]];
         end
      end
   end

   // A set arriving with the completion wins over the clear
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         write_enable_latch <= 1'b0;
      end else if (ce) begin
         if (wel_set) begin
            write_enable_latch <= 1'b1;
         end else if (op_end) begin
            write_enable_latch <= 1'b0;
         end
      end
   end
endmodule // sfpe_flash_cmd

// ===== sfpe_pkg.sv
// Constants, types and the two-flop synchroniser of the serial flash command block
`timescale 1ns/1ns

package sfpe_pkg;
   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_DTR_READ = 8'hed;
   localparam logic [7:0] OP_DTR_READ4 = 8'hee;
   localparam logic [7:0] OP_PROG = 8'h02;
   localparam logic [7:0] OP_PROG4 = 8'h12;
   localparam logic [7:0] OP_QIN_PROG = 8'h32;
   localparam logic [7:0] OP_QIN_PROG4 = 8'h34;
   localparam logic [7:0] OP_QUAD_PROG = 8'h33;
   localparam logic [7:0] OP_SECT_ERASE = 8'h20;

   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] ADDR3_BITS = 6'h18;
   localparam logic [5:0] ADDR4_BITS = 6'h20;
   localparam logic [4:0] ADDR3_BYTES = 5'h03;
   localparam logic [4:0] ADDR4_BYTES = 5'h04;
   localparam int MODE_HI = 5;
   localparam int MODE_LO = 4;
   localparam logic [1:0] MODE_CONT = 2'h2;
   // Dummy clocks per latency code; the mode byte is the first of them
   localparam logic [4:0] DUMMY_LC0 = 5'h06;
   localparam logic [4:0] DUMMY_LC1 = 5'h04;
   localparam logic [4:0] DUMMY_LC2 = 5'h08;
   localparam logic [4:0] DUMMY_LC3 = 5'h0a;

   // ------------------------------------------------------------
   // Array geometry and protection
   // ------------------------------------------------------------
   localparam int MEM_AW = 25;
   localparam int PAGE_BYTES = 256;
   localparam logic [11:0] PAGE_LAST = 12'h0ff;
   localparam logic [11:0] SECTOR_LAST = 12'hfff;
   localparam int PAGE_AW = 8;
   localparam int SECTOR_AW = 12;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam longint PROT_SMALL_UNIT = 4096;
   localparam longint PROT_SMALL_MAX = 32768;
   localparam longint PROT_BLOCK_UNIT = 65536;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_PP_NS = 400000;
   localparam int T_SE_NS = 45000000;
   localparam int PP_CYC = (T_PP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SE_CYC = (T_SE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LINK_SYNC_W = 7;

   typedef enum {L_CMD, L_ADDR, L_RDHDR, L_RDATA, L_PROG, L_TAIL, L_IGNORE} sfpe_lstate_t;
   typedef enum {K_NONE, K_PROG, K_ERASE} sfpe_kind_t;
   typedef enum {C_IDLE, C_WORK, C_WAIT} sfpe_cstate_t;
endpackage

module sfpe_sync #(
   parameter int W = 1
) (
   input wire logic clk, // Destination clock
   input wire logic en, // Clock enable
   input wire logic [W-1:0] d, // Asynchronous level
   output logic [W-1:0] q // Synchronised level
);
   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      if (en) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // sfpe_sync

// ===== sfpe_flash_cmd_props.sv
// Assertion checker for the serial flash command block
`timescale 1ns/1ns
module sfpe_flash_cmd_props #(
   parameter int PP_CYCLES = 300,
   parameter int SE_CYCLES = 4200
) (
   input wire logic ref_clk, // Core clock
   input wire logic rst_n, // Reset, active low
   input wire logic ce, // Core clock enable
   input wire logic sclk, // Link clock
   input wire logic cs_n, // Chip select
   input wire logic [3:0] io_out, // Lanes out
   input wire logic [3:0] io_oe, // Lane enables
   input wire logic wel_set, // Latch set pulse
   input wire logic write_enable_latch, // Latch state
   input wire logic busy // Timed cycle running
);
   int busy_len;
   // Enabled cycles of the current busy stretch, so the end can be tied to the timer
   always_ff @(posedge ref_clk) begin
      busy_len <= !busy ? 0 : ce ? busy_len + 1 : busy_len;
   end
   chk_busy_length: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(busy) |-> (busy_len == PP_CYCLES || busy_len == SE_CYCLES))
      else $error("busy stood for a wrong number of cycles");
   chk_end_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(busy) |-> !write_enable_latch)
      else $error("latch still set after the timed cycle");
   chk_busy_needs_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(busy) |-> write_enable_latch && $past(write_enable_latch))
      else $error("timed cycle started without the latch");
   chk_busy_after_cs: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(busy) |-> cs_n && $past(cs_n, 2))
      else $error("timed cycle started while selected");
   chk_latch_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wel_set |=> write_enable_latch)
      else $error("latch did not set");
   chk_latch_source: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(write_enable_latch) |-> $past(wel_set))
      else $error("latch set without a request");
   chk_latch_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
      busy |-> write_enable_latch)
      else $error("latch dropped during the timed cycle");
   chk_lanes_whole: assert property (@(negedge sclk) disable iff (!rst_n)
      io_oe != 4'h0 |-> io_oe == 4'hf && !cs_n)
      else $error("partial or unselected lane drive");
   chk_no_read_busy: assert property (@(posedge sclk) disable iff (!rst_n)
      $rose(io_oe[0]) |-> !busy)
      else $error("read answered during a timed cycle");
   chk_idle_lanes: assert property (@(posedge ref_clk) disable iff (!rst_n)
      io_oe == 4'h0 |-> io_out == 4'h0)
      else $error("lanes show data while released");
endmodule // sfpe_flash_cmd_props

// ===== sfpe_host_model.sv
// Host controller model driving the serial flash link
`timescale 1ns/1ns
module sfpe_host_model (
   output logic sclk, // Link clock, still between frames
   output logic cs_n, // Chip select
   output logic [3:0] io_drv, // Lanes driven by the host
   input wire logic [3:0] io_wire // Resolved lane levels
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io_drv = 4'h5;
   end
   // One link clock: a set up for the rise, b for the fall
   task automatic tick(input logic [3:0] a, input logic [3:0] b, output logic [7:0] q);
      io_drv = a;
      #40 sclk = 1'b1;
      #40 q[7:4] = io_wire;
      io_drv = b;
      #40 sclk = 1'b0;
      #40 q[3:0] = io_wire;
   endtask
   // Unused lanes toggle so a stale level is never mistaken for data
   task automatic bits(input logic [7:0] v, input int n);
      logic [7:0] q;
      for (int i = 7; i > 7 - n; i--) tick({~io_drv[3:1], v[i]}, {~io_drv[3:1], v[i]}, q);
   endtask
   task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int na,
                      input logic quad, input logic [7:0] d[$], input int cut);
      logic [7:0] q;
      cs_n = 1'b0;
      bits(op, 8);
      for (int i = na - 1; i >= 0; i--) bits(a[8*i +: 8], 8);
      foreach (d[i]) begin
         if (quad) begin
            tick(d[i][7:4], d[i][7:4], q);
            tick(d[i][3:0], d[i][3:0], q);
         end else bits(d[i], 8);
      end
      if (cut > 0) bits(8'ha5, cut);
      #40 cs_n = 1'b1;
      io_drv = ~io_drv;
   endtask
   task automatic rd(input logic skip, input logic [23:0] a, input logic [7:0] m,
                     input int dum, input int n, output logic [7:0] q[$]);
      logic [7:0] b;
      q = {};
      cs_n = 1'b0;
      if (!skip) bits(sfpe_pkg::OP_DTR_READ, 8);
      for (int i = 2; i >= 0; i--) tick(a[8*i+4 +: 4], a[8*i +: 4], b);
      tick(m[7:4], m[3:0], b);
      for (int i = 1; i < dum + n; i++) begin
         tick(~io_drv, io_drv, b);
         if (i >= dum) q.push_back(b);
      end
      #40 cs_n = 1'b1;
   endtask
endmodule // sfpe_host_model

// ===== testbench.sv
// Self-checking bench for the serial flash command block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; \
   if ((g) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
   localparam int PP = 300;
   localparam int SE = 4200;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wel_set = 1'b0;
   logic [1:0] lc = 2'h2;
   logic [3:0] bp = 4'h0;
   logic tbs = 1'b0;
   logic sec = 1'b0;
   logic qe = 1'b1;
   logic ce = 1'b1;
   logic cmp = 1'b0;
   logic sclk, cs_n, write_enable_latch, busy;
   logic [3:0] io_drv, io_out, io_oe, io_wire;
   logic [7:0] em [0:511];
   logic [7:0] q[$];
   logic [23:0] ra [4] = '{24'hfd, 24'h0, 24'h20, 24'h3f};
   int errors = 0;
   int n_tests = 0;
   int seed = 81594;
   assign io_wire = (io_oe & io_out) | (~io_oe & io_drv);
   always #20 ref_clk = ~ref_clk;
   sfpe_host_model u_host (.sclk(sclk), .cs_n(cs_n), .io_drv(io_drv), .io_wire(io_wire));
   sfpe_flash_cmd #(.AW(14), .PP_CYCLES(PP), .SE_CYCLES(SE)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .cs_n(cs_n),
      .io_in(io_wire), .io_out(io_out), .io_oe(io_oe), .quad_enable(qe),
      .four_lane_command_mode(1'b0), .latency_code(lc), .protect_complement(cmp),
      .top_bottom_select(tbs), .small_region_protect(sec), .block_protect_bit3(bp[3]),
      .block_protect_bit2(bp[2]), .block_protect_bit1(bp[1]), .block_protect_bit0(bp[0]),
      .wel_set(wel_set), .write_enable_latch(write_enable_latch), .busy(busy));
   function automatic int dum_of(input logic [1:0] c);
      case (c)
         2'h0: return sfpe_pkg::DUMMY_LC0;
         2'h1: return sfpe_pkg::DUMMY_LC1;
         2'h2: return sfpe_pkg::DUMMY_LC2;
         default: return sfpe_pkg::DUMMY_LC3;
      endcase
   endfunction
   task automatic pulse_wel();
      @(negedge ref_clk) wel_set = 1'b1;
      @(negedge ref_clk) wel_set = 1'b0;
   endtask
   task automatic run_op(input int len);
      int k;
      k = 0;
      while (busy !== 1'b1 && k < 10) begin
         @(negedge ref_clk);
         k++;
      end
      `CHK("busy start", 1'b1, busy)
      k = 0;
      while (busy === 1'b1 && k < len + 5) begin
         @(negedge ref_clk);
         k++;
      end
      `CHK("busy length", len, k)
      `CHK("latch cleared", 1'b0, write_enable_latch)
      repeat (8) @(negedge ref_clk);
   endtask
   task automatic no_op(input logic wel_exp);
      int k;
      k = 0;
      repeat (20) begin
         @(negedge ref_clk);
         if (busy !== 1'b0) k++;
      end
      `CHK("busy idle", 0, k)
      `CHK("latch kept", wel_exp, write_enable_latch)
   endtask
   task automatic rd_chk(input logic skip, input logic [23:0] a, input logic [7:0] m);
      repeat (5) @(negedge ref_clk);
      u_host.rd(skip, a, m, dum_of(lc), 3, q);
      for (int i = 0; i < 3; i++) `CHK("read byte", em[a + i], q[i])
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      errors++;
      report_and_stop();
   end
   initial begin
      int r;
      logic [7:0] d[$];
      for (int i = 0; i < 512; i++) em[i] = 8'hff;
      // Link clocks while in reset so the link side starts clean
      u_host.bits(8'hff, 8);
      @(negedge ref_clk) rst_n = 1'b1;
      // The link sees the release only after a few more idle clocks
      u_host.bits(8'hff, 3);
      repeat (5) @(negedge ref_clk);
      r = $random(seed);
      pulse_wel();
      u_host.cmd(sfpe_pkg::OP_SECT_ERASE, {20'h0, r[11:0]}, 3, 1'b0, d, 0);
      run_op(SE);
      d = {8'h00};
      u_host.cmd(sfpe_pkg::OP_PROG, 32'h40, 3, 1'b0, d, 0);
      no_op(1'b0);
      pulse_wel();
      u_host.cmd(sfpe_pkg::OP_PROG, 32'h40, 3, 1'b0, d, 3);
      no_op(1'b1);
      r = $random(seed);
      @(negedge ref_clk) bp = r[3:0] | 4'h1;
      tbs = r[4];
      sec = r[5];
      u_host.cmd(sfpe_pkg::OP_PROG, 32'h40, 3, 1'b0, d, 0);
      no_op(1'b1);
      @(negedge ref_clk) bp = 4'h0;
      cmp = 1'b1;
      u_host.cmd(sfpe_pkg::OP_PROG, 32'h40, 3, 1'b0, d, 0);
      no_op(1'b1);
      @(negedge ref_clk) cmp = 1'b0;
      d = {};
      for (int i = 0; i < 4; i++) d.push_back(8'($random(seed)));
      u_host.cmd(sfpe_pkg::OP_PROG, 32'hfe, 3, 1'b0, d, 0);
      for (int i = 0; i < 4; i++) em[8'(8'hfe + i)] &= d[i];
      fork
         run_op(PP);
         begin
            repeat (20) @(negedge ref_clk);
            u_host.cmd(sfpe_pkg::OP_PROG, 32'h40, 3, 1'b0, d, 0);
         end
      join
      no_op(1'b0);
      pulse_wel();
      @(negedge ref_clk) qe = 1'b0;
      u_host.cmd(sfpe_pkg::OP_QUAD_PROG, 32'h20, 3, 1'b1, d, 0);
      no_op(1'b1);
      @(negedge ref_clk) qe = 1'b1;
      d = {8'($random(seed)), 8'h3c};
      u_host.cmd(sfpe_pkg::OP_QIN_PROG4, 32'h20, 4, 1'b1, d, 0);
      for (int i = 0; i < 2; i++) em[32 + i] &= d[i];
      // Clock enable low for ten cycles stretches busy by as many
      fork
         run_op(PP + 10);
         begin
            repeat (40) @(negedge ref_clk);
            ce = 1'b0;
            repeat (10) @(negedge ref_clk);
            ce = 1'b1;
         end
      join
      // Each latency code once; the last read leaves continuous mode on
      for (int c = 0; c < 4; c++) begin
         @(negedge ref_clk) lc = 2'(c);
         rd_chk(1'b0, ra[c], (c == 3) ? 8'h20 : 8'h0f);
      end
      rd_chk(1'b1, 24'h1e, 8'hff);
      rd_chk(1'b0, 24'h3e, 8'h00);
      report_and_stop();
   end
endmodule // testbench
bind sfpe_flash_cmd sfpe_flash_cmd_props #(.PP_CYCLES(PP_CYCLES), .SE_CYCLES(SE_CYCLES)) u_props (
   .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .io_out(io_out), .io_oe(io_oe),
   .wel_set(wel_set), .write_enable_latch(write_enable_latch), .busy(busy), .ce(ce));
